// ==== rtl/fcwd_decoder.sv ====
// Top of the fieldbus command word decoder: latches each word and drives the drive sequencer.
// Assumes the adapter logic and drive share i_sys_clk; config straps and fault come from same-clock logic.
`timescale 1ns/1ps
module fcwd_decoder (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // Command word from the adapter
    input wire logic i_cmd_wr,
    input wire logic [15:0] i_cmd_word,
    input wire logic [15:0] i_ref_word,
    // Source selection configuration
    input wire fcwd_pkg::fcwd_cfg_t i_cfg,
    input wire logic i_run_enable_ext,
    // Drive feedback
    input wire logic i_fault,
    input wire logic i_at_zero_speed,
    // Sequencer outputs
    output fcwd_pkg::fcwd_state_t o_state,
    output fcwd_pkg::fcwd_ramp_t o_ramp,
    output logic o_drive_on,
    output logic o_emerg_ramp,
    output logic o_fault_clear,
    output logic [15:0] o_ref,
    output logic [15:0] o_status_word
);
    fcwd_pkg::fcwd_state_t state_q, state_d;
    logic [15:0] held_cmd;
    logic [15:0] held_ref;
    logic held_new;
    logic [15:0] eff_cmd;
    logic remote_ok;
    logic ramp_stop_req;
    logic coast_req;
    logic emerg_req;
    logic run_en;
    logic run_req;
    logic reset_bit_q;
    logic reset_edge;
    logic fault_clear_q;
    logic [15:0] emerg_cnt_q, emerg_cnt_d;
    logic emerg_done;
    fcwd_pkg::fcwd_ramp_t ramp_q, ramp_d;
    logic [15:0] ref_q;
    logic [15:0] status_q, status_d;

    fcwd_word_latch u_latch (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_wr(i_cmd_wr),
        .i_cmd(i_cmd_word),
        .i_ref(i_ref_word),
        .o_cmd(held_cmd),
        .o_ref(held_ref),
        .o_new(held_new)
    );

    // Stop bits pass regardless; the rest only with remote set, so a local master cannot run the drive.
    assign remote_ok = held_cmd[fcwd_pkg::BIT_REMOTE];
    assign eff_cmd = remote_ok ? held_cmd : (held_cmd & fcwd_pkg::STOP_MASK);

    assign ramp_stop_req = !eff_cmd[fcwd_pkg::BIT_RAMP_STOP];
    assign coast_req = !eff_cmd[fcwd_pkg::BIT_COAST_STOP];
    assign emerg_req = !eff_cmd[fcwd_pkg::BIT_EMERG_STOP];
    // When the fieldbus supplies run enable, the run bit is the enable itself.
    assign run_en = i_cfg.run_from_bus ? eff_cmd[fcwd_pkg::BIT_RUN] : i_run_enable_ext;
    assign run_req = eff_cmd[fcwd_pkg::BIT_RUN] && run_en;
    assign reset_edge = i_cfg.reset_from_bus && remote_ok && held_cmd[fcwd_pkg::BIT_FAULT_RESET]
        && !reset_bit_q;
    assign emerg_done = (emerg_cnt_q == 16'h0000) || i_at_zero_speed;

    // Sequencer: stop interlocks outrank everything except an active fault.
    always_comb begin
        state_d = state_q;
        case (state_q)
            fcwd_pkg::FCWD_FAULT: begin
                if (reset_edge) begin
                    state_d = fcwd_pkg::FCWD_INHIBITED;
                end
            end
            fcwd_pkg::FCWD_COAST_STOP: begin
                state_d = fcwd_pkg::FCWD_INHIBITED;
            end
            fcwd_pkg::FCWD_EMERG_STOP: begin
                if (coast_req) begin
                    state_d = fcwd_pkg::FCWD_COAST_STOP;
                end else if (emerg_done) begin
                    state_d = fcwd_pkg::FCWD_INHIBITED;
                end
            end
            fcwd_pkg::FCWD_RAMP_STOP: begin
                if (coast_req) begin
                    state_d = fcwd_pkg::FCWD_COAST_STOP;
                end else if (emerg_req) begin
                    state_d = fcwd_pkg::FCWD_EMERG_STOP;
                end else if (i_at_zero_speed) begin
                    state_d = fcwd_pkg::FCWD_READY_ON;
                end
            end
            fcwd_pkg::FCWD_INHIBITED: begin
                // Leaving inhibit needs a ramp-stop command first, as a restart safeguard.
                if (!coast_req && !emerg_req && ramp_stop_req) begin
                    state_d = fcwd_pkg::FCWD_READY_ON;
                end
            end
            fcwd_pkg::FCWD_READY_ON: begin
                if (coast_req || emerg_req) begin
                    state_d = fcwd_pkg::FCWD_INHIBITED;
                end else if (!ramp_stop_req) begin
                    state_d = fcwd_pkg::FCWD_READY_RUN;
                end
            end
            fcwd_pkg::FCWD_READY_RUN: begin
                if (coast_req) begin
                    state_d = fcwd_pkg::FCWD_INHIBITED;
                end else if (emerg_req) begin
                    state_d = fcwd_pkg::FCWD_INHIBITED;
                end else if (ramp_stop_req) begin
                    state_d = fcwd_pkg::FCWD_READY_ON;
                end else if (run_req) begin
                    state_d = fcwd_pkg::FCWD_OPERATING;
                end
            end
            fcwd_pkg::FCWD_OPERATING: begin
                if (coast_req) begin
                    state_d = fcwd_pkg::FCWD_COAST_STOP;
                end else if (emerg_req) begin
                    state_d = fcwd_pkg::FCWD_EMERG_STOP;
                end else if (ramp_stop_req) begin
                    state_d = fcwd_pkg::FCWD_RAMP_STOP;
                end else if (!run_req) begin
                    state_d = fcwd_pkg::FCWD_READY_RUN;
                end
            end
            default: begin
                state_d = fcwd_pkg::FCWD_INHIBITED;
            end
        endcase
        // A live fault overrides every request except a fault reset edge taken in the fault state.
        if (i_fault && state_q != fcwd_pkg::FCWD_FAULT) begin
            state_d = fcwd_pkg::FCWD_FAULT;
        end
    end

    // Emergency ramp timer loads on entry and counts down while the stop is in progress.
    always_comb begin
        emerg_cnt_d = emerg_cnt_q;
        if (state_q != fcwd_pkg::FCWD_EMERG_STOP) begin
            emerg_cnt_d = 16'(fcwd_pkg::EMERG_CYCLES);
        end else if (emerg_cnt_q != 16'h0000) begin
            emerg_cnt_d = emerg_cnt_q - 16'h0001;
        end
    end

    // Ramp controls follow the word in every sequencer state; all but the user bits need remote set.
    always_comb begin
        ramp_d.ramp_out_zero = (eff_cmd[fcwd_pkg::BIT_RAMP_OUT_CLR] == fcwd_pkg::RAMP_OUT_FORCE_LEVEL)
            && remote_ok;
        ramp_d.ramp_hold = remote_ok && !eff_cmd[fcwd_pkg::BIT_RAMP_HOLD];
        ramp_d.ramp_in_zero = i_cfg.ramp_in_from_bus && remote_ok
            && !eff_cmd[fcwd_pkg::BIT_RAMP_IN_CLR];
        // The master keeps bits four to six at zero while jogging; jog is refused otherwise.
        ramp_d.jog_one = eff_cmd[fcwd_pkg::BIT_JOG_ONE]
            && (eff_cmd[fcwd_pkg::BIT_RAMP_IN_CLR:fcwd_pkg::BIT_RAMP_OUT_CLR] == 3'h0);
        ramp_d.jog_two = eff_cmd[fcwd_pkg::BIT_JOG_TWO]
            && (eff_cmd[fcwd_pkg::BIT_RAMP_IN_CLR:fcwd_pkg::BIT_RAMP_OUT_CLR] == 3'h0);
        ramp_d.location_b = i_cfg.location_from_bus && eff_cmd[fcwd_pkg::BIT_LOCATION];
        ramp_d.user_bits = held_cmd[fcwd_pkg::BIT_USER_LO +: 4];
    end

    // Status word mirrors sequencer state back to the master.
    always_comb begin
        status_d = 16'h0000;
        status_d[fcwd_pkg::STAT_READY_ON] = (state_q == fcwd_pkg::FCWD_READY_ON)
            || (state_q == fcwd_pkg::FCWD_READY_RUN) || (state_q == fcwd_pkg::FCWD_OPERATING);
        status_d[fcwd_pkg::STAT_READY_RUN] = (state_q == fcwd_pkg::FCWD_READY_RUN)
            || (state_q == fcwd_pkg::FCWD_OPERATING);
        status_d[fcwd_pkg::STAT_READY_REF] = (state_q == fcwd_pkg::FCWD_OPERATING);
        status_d[fcwd_pkg::STAT_TRIPPED] = (state_q == fcwd_pkg::FCWD_FAULT);
        status_d[fcwd_pkg::STAT_COAST_OFF] = !coast_req;
        status_d[fcwd_pkg::STAT_EMERG_OFF] = !emerg_req;
        status_d[fcwd_pkg::STAT_INHIBITED] = (state_q == fcwd_pkg::FCWD_INHIBITED);
        status_d[fcwd_pkg::STAT_REMOTE] = remote_ok;
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= fcwd_pkg::FCWD_INHIBITED;
            emerg_cnt_q <= 16'h0000;
            reset_bit_q <= 1'b0;
            fault_clear_q <= 1'b0;
            ramp_q <= '0;
            ref_q <= fcwd_pkg::REF_RESET;
            status_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            emerg_cnt_q <= emerg_cnt_d;
            reset_bit_q <= held_cmd[fcwd_pkg::BIT_FAULT_RESET];
            fault_clear_q <= reset_edge && (state_q == fcwd_pkg::FCWD_FAULT);
            ramp_q <= ramp_d;
            // Reference passes untouched as a two's complement word; held at zero off remote.
            ref_q <= remote_ok ? held_ref : fcwd_pkg::REF_RESET;
            status_q <= status_d;
        end
    end

    assign o_state = state_q;
    assign o_ramp = ramp_q;
    // Drive stays energised through a ramp or emergency stop; coast removes it at once.
    assign o_drive_on = (state_q == fcwd_pkg::FCWD_OPERATING) || (state_q == fcwd_pkg::FCWD_RAMP_STOP)
        || (state_q == fcwd_pkg::FCWD_EMERG_STOP);
    assign o_emerg_ramp = (state_q == fcwd_pkg::FCWD_EMERG_STOP);
    assign o_fault_clear = fault_clear_q;
    assign o_ref = ref_q;
    assign o_status_word = status_q;

    coast_stop_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (state_q == fcwd_pkg::FCWD_OPERATING && coast_req && !i_fault)
        |=> state_q == fcwd_pkg::FCWD_COAST_STOP ##1 state_q == fcwd_pkg::FCWD_INHIBITED)
        else $error("coast stop did not reach inhibit");
    emerg_stop_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (state_q == fcwd_pkg::FCWD_OPERATING && emerg_req && !coast_req && !i_fault)
        |=> state_q == fcwd_pkg::FCWD_EMERG_STOP && o_emerg_ramp)
        else $error("emergency stop not entered");
    ramp_stop_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (state_q == fcwd_pkg::FCWD_OPERATING && ramp_stop_req && !coast_req && !emerg_req && !i_fault)
        |=> state_q == fcwd_pkg::FCWD_RAMP_STOP) else $error("ramp stop not entered");
    ready_run_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (state_q == fcwd_pkg::FCWD_READY_ON && !ramp_stop_req && !coast_req && !emerg_req && !i_fault)
        |=> state_q == fcwd_pkg::FCWD_READY_RUN) else $error("ready to operate not reached");
    run_enter_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (state_q == fcwd_pkg::FCWD_READY_RUN && run_req && !ramp_stop_req && !coast_req && !emerg_req
        && !i_fault) |=> state_q == fcwd_pkg::FCWD_OPERATING) else $error("operation not enabled");
    run_inhibit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (state_q == fcwd_pkg::FCWD_OPERATING && !run_req && !ramp_stop_req && !coast_req && !emerg_req
        && !i_fault) |=> state_q == fcwd_pkg::FCWD_READY_RUN) else $error("run bit low not inhibiting");
    fault_reset_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (state_q == fcwd_pkg::FCWD_FAULT && !i_cfg.reset_from_bus) |=> state_q == fcwd_pkg::FCWD_FAULT)
        else $error("fault cleared without bus reset source");
    fault_edge_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (state_q == fcwd_pkg::FCWD_FAULT && reset_edge) |=> o_fault_clear
        && state_q == fcwd_pkg::FCWD_INHIBITED) else $error("fault reset edge lost");
    ramp_in_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        !i_cfg.ramp_in_from_bus |=> !o_ramp.ramp_in_zero) else $error("ramp input clear not gated");
    remote_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        !held_cmd[fcwd_pkg::BIT_REMOTE] |=> !o_ramp.jog_one && !o_ramp.jog_two && o_ref == 16'h0000)
        else $error("command passed without remote");
    location_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (i_cfg.location_from_bus && remote_ok) |=> o_ramp.location_b == $past(held_cmd[fcwd_pkg::BIT_LOCATION]))
        else $error("location select wrong");
endmodule : fcwd_decoder

// ==== rtl/fcwd_pkg.sv ====
// Package for the fieldbus command word decoder: bit positions, reset values, state encoding, carriers.
// Assumes a single drive clock; the command word arrives from adapter logic on the same clock.
package fcwd_pkg;
    localparam int unsigned BIT_RAMP_STOP = 0;
    localparam int unsigned BIT_COAST_STOP = 1;
    localparam int unsigned BIT_EMERG_STOP = 2;
    localparam int unsigned BIT_RUN = 3;
    localparam int unsigned BIT_RAMP_OUT_CLR = 4;
    localparam int unsigned BIT_RAMP_HOLD = 5;
    localparam int unsigned BIT_RAMP_IN_CLR = 6;
    localparam int unsigned BIT_FAULT_RESET = 7;
    localparam int unsigned BIT_JOG_ONE = 8;
    localparam int unsigned BIT_JOG_TWO = 9;
    localparam int unsigned BIT_REMOTE = 10;
    localparam int unsigned BIT_LOCATION = 11;
    localparam int unsigned BIT_USER_LO = 12;
    // Stop bits always pass, even with remote cleared.
    localparam logic [15:0] STOP_MASK = 16'h0007;
    // Safe word: all stops asserted, everything else off.
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [15:0] REF_RESET = 16'h0000;
    // Ramp-output-clear forcing level; the printed table leaves it unclear, so it is a constant.
    localparam logic RAMP_OUT_FORCE_LEVEL = 1'b1;
    // Emergency-stop time as printed is drive-parameter defined; a default is given in microseconds.
    localparam int unsigned EMERG_TIME_US = 10;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned EMERG_CYCLES = EMERG_TIME_US * CLK_MHZ;
    localparam int unsigned STAT_READY_ON = 0;
    localparam int unsigned STAT_READY_RUN = 1;
    localparam int unsigned STAT_READY_REF = 2;
    localparam int unsigned STAT_TRIPPED = 3;
    localparam int unsigned STAT_COAST_OFF = 4;
    localparam int unsigned STAT_EMERG_OFF = 5;
    localparam int unsigned STAT_INHIBITED = 6;
    localparam int unsigned STAT_REMOTE = 9;

    typedef enum logic [2:0] {
        FCWD_INHIBITED = 3'b000,
        FCWD_READY_ON = 3'b001,
        FCWD_READY_RUN = 3'b011,
        FCWD_OPERATING = 3'b010,
        FCWD_RAMP_STOP = 3'b110,
        FCWD_COAST_STOP = 3'b111,
        FCWD_EMERG_STOP = 3'b101,
        FCWD_FAULT = 3'b100
    } fcwd_state_t;

    typedef struct packed {
        logic ramp_out_zero;
        logic ramp_hold;
        logic ramp_in_zero;
        logic jog_one;
        logic jog_two;
        logic location_b;
        logic [3:0] user_bits;
    } fcwd_ramp_t;

    typedef struct packed {
        logic run_from_bus;
        logic ramp_in_from_bus;
        logic reset_from_bus;
        logic location_from_bus;
    } fcwd_cfg_t;
endpackage : fcwd_pkg

// ==== rtl/fcwd_word_latch.sv ====
// Holds the command word and reference as one unit when the strobe arrives.
// Assumes the strobe and data come from logic on the same clock.
`timescale 1ns/1ps
module fcwd_word_latch (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // Received words
    input wire logic i_wr,
    input wire logic [15:0] i_cmd,
    input wire logic [15:0] i_ref,
    // Held words
    output logic [15:0] o_cmd,
    output logic [15:0] o_ref,
    output logic o_new
);
    logic [15:0] cmd_q;
    logic [15:0] ref_q;
    logic new_q;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cmd_q <= fcwd_pkg::CMD_RESET;
            ref_q <= fcwd_pkg::REF_RESET;
            new_q <= 1'b0;
        end else begin
            new_q <= i_wr;
            if (i_wr) begin
                cmd_q <= i_cmd;
                ref_q <= i_ref;
            end
        end
    end

    assign o_cmd = cmd_q;
    assign o_ref = ref_q;
    assign o_new = new_q;

    word_latch_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_wr |=> (cmd_q == $past(i_cmd)) && new_q) else $error("command word not latched whole");
endmodule : fcwd_word_latch

// ==== tb/fcwd_decoder_tb_top.sv ====
// Self-checking bench for the fieldbus command word decoder.
// Assumes the master model drives the word lines and the bench drives config and feedback.
`timescale 1ns/1ps
module fcwd_decoder_tb_top;
    logic i_sys_clk, i_resetn, i_run_enable_ext, i_fault, i_at_zero_speed, cmd_wr;
    logic [15:0] cmd_word, ref_word, o_ref, o_status_word, w, r;
    logic [31:0] k;
    fcwd_pkg::fcwd_cfg_t cfg;
    fcwd_pkg::fcwd_state_t o_state;
    fcwd_pkg::fcwd_ramp_t o_ramp;
    logic o_drive_on, o_emerg_ramp, o_fault_clear;
    int n_fail, checks, n_clr;
    integer seed;

    fcwd_master_model fcwd_master_model_inst (.i_sys_clk(i_sys_clk), .o_cmd_wr(cmd_wr), .o_cmd_word(cmd_word),
        .o_ref_word(ref_word));
    fcwd_decoder fcwd_decoder_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_cmd_wr(cmd_wr),
        .i_cmd_word(cmd_word), .i_ref_word(ref_word), .i_cfg(cfg), .i_run_enable_ext(i_run_enable_ext),
        .i_fault(i_fault), .i_at_zero_speed(i_at_zero_speed), .o_state(o_state), .o_ramp(o_ramp),
        .o_drive_on(o_drive_on), .o_emerg_ramp(o_emerg_ramp), .o_fault_clear(o_fault_clear), .o_ref(o_ref),
        .o_status_word(o_status_word));

    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end

    always @(posedge i_sys_clk) begin
        if (o_fault_clear === 1'b1) n_clr++;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude

    task automatic put(input logic [15:0] c);
        fcwd_master_model_inst.send(c, r, 1'b1);
    endtask : put

    // Bounded wait: the longest legal stay is the emergency ramp count.
    task automatic wait_st(input fcwd_pkg::fcwd_state_t s);
        for (int i = 0; i < 3000 && o_state !== s; i++) @(negedge i_sys_clk);
        chk({13'h0000, o_state}, {13'h0000, s}, "state");
    endtask : wait_st

    task automatic go_op();
        put(16'h040E);
        wait_st(fcwd_pkg::FCWD_READY_ON);
        put(16'h040F);
        wait_st(fcwd_pkg::FCWD_READY_RUN);
        put(16'h042F);
        wait_st(fcwd_pkg::FCWD_OPERATING);
    endtask : go_op

    function automatic fcwd_pkg::fcwd_ramp_t exp_ramp(input logic [15:0] c, input fcwd_pkg::fcwd_cfg_t g);
        logic rm;
        rm = c[fcwd_pkg::BIT_REMOTE];
        exp_ramp.ramp_out_zero = rm & (c[fcwd_pkg::BIT_RAMP_OUT_CLR] == fcwd_pkg::RAMP_OUT_FORCE_LEVEL);
        exp_ramp.ramp_hold = rm & ~c[fcwd_pkg::BIT_RAMP_HOLD];
        exp_ramp.ramp_in_zero = rm & g.ramp_in_from_bus & ~c[fcwd_pkg::BIT_RAMP_IN_CLR];
        exp_ramp.jog_one = rm & c[fcwd_pkg::BIT_JOG_ONE] & (c[6:4] == 3'b000);
        exp_ramp.jog_two = rm & c[fcwd_pkg::BIT_JOG_TWO] & (c[6:4] == 3'b000);
        exp_ramp.location_b = rm & g.location_from_bus & c[fcwd_pkg::BIT_LOCATION];
        exp_ramp.user_bits = c[15:12];
    endfunction : exp_ramp

    initial begin
        #400000;
        n_fail++;
        conclude();
    end

    initial begin
        seed = 32'hA7EDC82F;
        {i_resetn, i_run_enable_ext, i_fault, i_at_zero_speed} = 4'h0;
        cfg = 4'hF;
        r = 16'h0000;
        repeat (12) @(negedge i_sys_clk);
        chk({13'h0000, o_state}, 16'h0000, "reset state");
        chk(o_ref, 16'h0000, "reset ref");
        i_resetn = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        chk(o_status_word, 16'h0040, "reset status");
        $display("test reset done");
        // Run enable taken from outside first, then from the word itself.
        r = fcwd_master_model_inst.mk_ref(1'b1, 15'h1234);
        put(16'h040E);
        wait_st(fcwd_pkg::FCWD_READY_ON);
        put(16'h040F);
        wait_st(fcwd_pkg::FCWD_READY_RUN);
        cfg.run_from_bus = 1'b0;
        put(16'h042F);
        repeat (10) @(negedge i_sys_clk);
        chk({13'h0000, o_state}, {13'h0000, fcwd_pkg::FCWD_READY_RUN}, "no enable");
        i_run_enable_ext = 1'b1;
        wait_st(fcwd_pkg::FCWD_OPERATING);
        chk({15'h0000, o_drive_on}, 16'h0001, "drive on");
        // The status word is registered from the state, so it trails the state by one cycle.
        @(negedge i_sys_clk);
        chk({15'h0000, o_status_word[2]}, 16'h0001, "operating bit");
        chk(o_ref, r, "ref");
        cfg.run_from_bus = 1'b1;
        put(16'h0427);
        wait_st(fcwd_pkg::FCWD_READY_RUN);
        $display("test run done");
        put(16'h042F);
        wait_st(fcwd_pkg::FCWD_OPERATING);
        put(16'h042E);
        wait_st(fcwd_pkg::FCWD_RAMP_STOP);
        chk({15'h0000, o_drive_on}, 16'h0001, "ramping");
        i_at_zero_speed = 1'b1;
        wait_st(fcwd_pkg::FCWD_READY_ON);
        i_at_zero_speed = 1'b0;
        go_op();
        put(16'h042B);
        wait_st(fcwd_pkg::FCWD_EMERG_STOP);
        chk({14'h0000, o_emerg_ramp, o_status_word[5]}, 16'h0002, "emerg");
        wait_st(fcwd_pkg::FCWD_INHIBITED);
        // Coast stop must act even with remote control cleared.
        go_op();
        put(16'h002D);
        wait_st(fcwd_pkg::FCWD_COAST_STOP);
        chk({14'h0000, o_drive_on, o_status_word[4]}, 16'h0000, "coast");
        chk(o_ref, 16'h0000, "ref gated");
        i_at_zero_speed = 1'b1;
        wait_st(fcwd_pkg::FCWD_INHIBITED);
        i_at_zero_speed = 1'b0;
        $display("test stops done");
        put(16'h040E);
        wait_st(fcwd_pkg::FCWD_READY_ON);
        i_fault = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        i_fault = 1'b0;
        cfg.reset_from_bus = 1'b0;
        put(16'h040E);
        put(16'h048E);
        repeat (3) @(negedge i_sys_clk);
        chk({13'h0000, o_state}, {13'h0000, fcwd_pkg::FCWD_FAULT}, "reset ignored");
        chk({15'h0000, o_status_word[3]}, 16'h0001, "tripped");
        chk(n_clr[15:0], 16'h0000, "no clear");
        cfg.reset_from_bus = 1'b1;
        put(16'h040E);
        put(16'h048E);
        wait_st(fcwd_pkg::FCWD_READY_ON);
        chk(n_clr[15:0], 16'h0001, "clear pulse");
        put(16'h3506);
        repeat (3) @(negedge i_sys_clk);
        chk({6'h00, o_ramp}, {6'h00, exp_ramp(16'h3506, cfg)}, "jog corner");
        $display("test fault done");
        for (int n = 0; n < 40; n++) begin
            k = $random(seed);
            w = $random(seed);
            w[7:0] = {1'b0, w[6:4], 4'h6};
            cfg.ramp_in_from_bus = k[1];
            cfg.location_from_bus = k[2];
            r = fcwd_master_model_inst.mk_ref(k[3], k[18:4]);
            if (k[0]) fcwd_master_model_inst.send({~w[15:8], w[7:0]}, ~r, 1'b0);
            put(w);
            repeat (3) @(negedge i_sys_clk);
            chk({6'h00, o_ramp}, {6'h00, exp_ramp(w, cfg)}, "ramp");
            chk(o_ref, w[10] ? r : 16'h0000, "ref word");
        end
        $display("test random done");
        conclude();
    end
endmodule : fcwd_decoder_tb_top

// ==== tb/fcwd_master_model.sv ====
// Fieldbus master model: sends a command word and its reference as one unit on a strobe that drops after one cycle when last is set.
// Assumes callers enter send at a falling edge of the drive clock.
`timescale 1ns/1ps
module fcwd_master_model (
    // Clock
    input wire logic i_sys_clk,
    // Words towards the decoder
    output logic o_cmd_wr,
    output logic [15:0] o_cmd_word,
    output logic [15:0] o_ref_word
);
    initial begin
        o_cmd_wr = 1'b0;
        o_cmd_word = 16'h0000;
        o_ref_word = 16'h0000;
    end

    // Reverse direction is the two's complement of the positive magnitude.
    function automatic logic [15:0] mk_ref(input logic neg, input logic [14:0] mag);
        mk_ref = neg ? (16'h0000 - {1'b0, mag}) : {1'b0, mag};
    endfunction : mk_ref

    // With last cleared the strobe stays up, so back-to-back words need no gap.
    task automatic send(input logic [15:0] cmd, input logic [15:0] ref_w, input logic last);
        o_cmd_wr = 1'b1;
        o_cmd_word = cmd;
        o_ref_word = ref_w;
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        if (last) begin
            o_cmd_wr = 1'b0;
            // Stale lines show the inverse so a late sample cannot pass by luck.
            o_cmd_word = ~cmd;
            o_ref_word = ~ref_w;
        end
    endtask : send
endmodule : fcwd_master_model
